// >>> hdl/lpw_consts.vh
// constants for the low power wake controller
// assumes inclusion by bare name from the controller, monitor and bench files
`ifndef LPW_CONSTS_VH
`define LPW_CONSTS_VH

// ----------------------------------------
// power modes
// ----------------------------------------
`define LPW_MODE_RUN       2'h0
`define LPW_MODE_WAIT      2'h1
`define LPW_MODE_STOP      2'h2
`define LPW_MODE_RECOVER   2'h3

// ----------------------------------------
// vector addresses
// ----------------------------------------
`define LPW_VEC_RESET      16'hfffe
`define LPW_VEC_EXT_IRQ    16'hfffa
`define LPW_VEC_CLKGEN     16'hfff8
`define LPW_VEC_KEYPAD     16'hffe0
`define LPW_VEC_T1_OVF     16'hfff2
`define LPW_VEC_T1_CH1     16'hfff4
`define LPW_VEC_T1_CH0     16'hfff6
`define LPW_VEC_T2_OVF     16'hffec
`define LPW_VEC_T2_CH1     16'hffee
`define LPW_VEC_T2_CH0     16'hfff0
`define LPW_VEC_T2_CH5     16'hffcc
`define LPW_VEC_STEP       16'h0002
`define LPW_VEC_SPI_TX     16'hffe8
`define LPW_VEC_SPI_RX     16'hffea
`define LPW_VEC_SER_TX     16'hffe2
`define LPW_VEC_SER_RX     16'hffe4
`define LPW_VEC_SER_ERR    16'hffe6
`define LPW_VEC_ADC        16'hffde
`define LPW_VEC_TICK       16'hffdc
`define LPW_VEC_CAN_TX     16'hffd4

// ----------------------------------------
// interrupt source indices
// ----------------------------------------
`define LPW_NSRC           24
`define LPW_SRC_EXT        0
`define LPW_SRC_CLKGEN     1
`define LPW_SRC_T1_OVF     2
`define LPW_SRC_T1_CH1     3
`define LPW_SRC_T1_CH0     4
`define LPW_SRC_KEYPAD     5
`define LPW_SRC_SER_TX     6
`define LPW_SRC_SER_RX     7
`define LPW_SRC_SER_ERR    8
`define LPW_SRC_SPI_TX     9
`define LPW_SRC_SPI_RX     10
`define LPW_SRC_T2_OVF     11
`define LPW_SRC_T2_CH1     12
`define LPW_SRC_T2_CH0     13
`define LPW_SRC_ADC        14
`define LPW_SRC_TICK       15
`define LPW_SRC_CAN_TX     16
`define LPW_SRC_CAN_RX     17
`define LPW_SRC_CAN_ERR    18
`define LPW_SRC_CAN_WAKE   19
`define LPW_SRC_T2_CH2     20
`define LPW_SRC_T2_CH3     21
`define LPW_SRC_T2_CH4     22
`define LPW_SRC_T2_CH5     23

// ----------------------------------------
// stop recovery counts in reference clock cycles
// ----------------------------------------
`define LPW_RECOVER_LONG   12'hfff
`define LPW_RECOVER_SHORT  12'h01f

`endif

// >>> hdl/lpw_edge_det.v
// falling edge detector with a registered pulse output
// assumes the input is synchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none

module lpw_edge_det (
    input  wire clk_sys,
    input  wire reset_n,
    input  wire level_in,
    output reg  fall_pulse
);

    reg         last_ff;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            last_ff    <= 1'b1;
            fall_pulse <= 1'b0;
        end else begin
            last_ff    <= level_in;
            fall_pulse <= last_ff & ~level_in;
        end
    end

endmodule // lpw_edge_det

`default_nettype wire

// >>> hdl/lpw_wake_ctrl.v
// low power wake controller: wait and stop entry, wake decision, vector select
// assumes one clock clk_sys, peripheral requests synchronous and held until served
`timescale 1ns/10ps
`default_nettype none
`include "lpw_consts.vh"

// Function
// - watchdog keeps counting in wait; enabled timeout resets the chip
// - stop gates watchdog reference clock and clears integration unit counter
// - stop instruction only enters stop when stop enable bit is set
// - unmasked external interrupt wakes from wait and stop
// - unmasked keypad interrupt wakes from wait and stop
// - enabled supply monitor stays active; its reset ends wait or stop
// - serial unit runs in wait; its enabled interrupts wake from wait
// - serial unit halts in stop, keeps registers, resumes after stop exit
// - spi runs in wait, halts in stop, reset exit aborts it
// - timers run in wait, halt in stop, resume after interrupt exit
// - tick unit runs in wait; its register is blocked in wait and stop
// - tick unit runs in stop only with oscillator keep running set
// - can runs in wait with registers blocked; halts in stop
// - reset pin, watchdog or supply trip fetch the top reset vector
// - external pin falling edge in wait vectors through fffa
// - clock generator vectors at fff8, keypad at ffe0
// - timer one overflow, channel 1, channel 0 at fff2, fff4, fff6
// - timer two at ffec, ffee, fff0; channels 5 to 2 from ffcc upward
// - spi transmit and receive vectors at ffe8 and ffea
// - serial transmit, receive, error at ffe2, ffe4, ffe6
// - converter at ffde, tick unit at ffdc
// - can transmit, receive, error, wakeup from ffd4 upward
// - wait stops processor clock while the bus clock keeps running
// - stop exit holds clocks 4096 reference cycles, 32 with short recovery
module lpw_wake_ctrl (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        wait_instr,
    input  wire        stop_instr,
    input  wire        stop_enable,
    input  wire        short_recovery_select,
    input  wire        osc_keep_running,
    input  wire        ref_clk_tick,
    input  wire        reset_pin_n,
    input  wire        watchdog_enable,
    input  wire        watchdog_timeout,
    input  wire        supply_enable,
    input  wire        supply_reset_enable,
    input  wire        supply_trip_level,
    input  wire        ext_irq_pin,
    input  wire        ext_request_mask,
    input  wire        keypad_request,
    input  wire        keypad_request_mask,
    input  wire [23:0] irq_req,
    input  wire [23:0] irq_enable,
    input  wire        vector_ack,
    output wire        cpu_clk_en,
    output wire        bus_clk_en,
    output wire        watchdog_clk_en,
    output wire        sys_count_clear,
    output wire        serial_clk_en,
    output wire        spi_clk_en,
    output wire        spi_abort,
    output wire        timer_clk_en,
    output wire        tick_clk_en,
    output wire        tick_reg_access_en,
    output wire        can_clk_en,
    output wire        can_reg_access_en,
    output wire        supply_monitor_en,
    output wire        chip_reset_req,
    output reg         vector_valid,
    output reg  [15:0] vector_addr,
    output wire [1:0]  power_mode
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam [1:0] ST_RUN     = `LPW_MODE_RUN;
    localparam [1:0] ST_WAIT    = `LPW_MODE_WAIT;
    localparam [1:0] ST_STOP    = `LPW_MODE_STOP;
    localparam [1:0] ST_RECOVER = `LPW_MODE_RECOVER;

    reg  [1:0]  mode_ff;
    reg  [1:0]  nxt_mode;
    reg  [11:0] recover_cnt_ff;
    reg  [11:0] nxt_recover_cnt;
    reg         stop_clear_ff;
    reg         reset_exit_ff;
    reg         nxt_reset_exit;
    reg         ext_pend_ff;
    reg         nxt_vector_valid;
    reg  [15:0] nxt_vector_addr;
    reg  [15:0] irq_vec;
    reg         irq_any;
    integer     i;

    wire        ext_fall;
    wire        in_wait = (mode_ff == ST_WAIT);
    wire        in_stop = (mode_ff == ST_STOP);
    wire        in_rec  = (mode_ff == ST_RECOVER);

    lpw_edge_det u_ext_edge (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .level_in   (ext_irq_pin),
        .fall_pulse (ext_fall)
    );

    // ----------------------------------------
    // wake sources
    // ----------------------------------------
    wire wd_reset  = watchdog_enable & watchdog_timeout & ~in_stop;
    wire sup_reset = supply_enable & supply_reset_enable & supply_trip_level;
    wire any_reset = ~reset_pin_n | wd_reset | sup_reset;
    wire ext_wake  = ext_pend_ff & ~ext_request_mask;
    wire key_wake  = keypad_request & ~keypad_request_mask;
    wire tick_live = ~in_stop | osc_keep_running;
    wire [23:0] live_req = irq_req & irq_enable;
    wire stop_irq  = live_req[`LPW_SRC_TICK] & osc_keep_running;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ext_pend_ff <= 1'b0;
        end else if (ext_fall) begin
            ext_pend_ff <= 1'b1;
        end else if (vector_ack & vector_valid & (vector_addr == `LPW_VEC_EXT_IRQ)) begin
            ext_pend_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // vector priority: first source index wins
    // ----------------------------------------
    always @* begin
        irq_vec = `LPW_VEC_RESET;
        irq_any = 1'b0;
        for (i = `LPW_NSRC - 1; i >= 0; i = i - 1) begin
            if (live_req[i]) begin
                irq_any = 1'b1;
                case (i)
                    `LPW_SRC_CLKGEN:   irq_vec = `LPW_VEC_CLKGEN;
                    `LPW_SRC_KEYPAD:   irq_vec = `LPW_VEC_KEYPAD;
                    `LPW_SRC_T1_OVF:   irq_vec = `LPW_VEC_T1_OVF;
                    `LPW_SRC_T1_CH1:   irq_vec = `LPW_VEC_T1_CH1;
                    `LPW_SRC_T1_CH0:   irq_vec = `LPW_VEC_T1_CH0;
                    `LPW_SRC_T2_OVF:   irq_vec = `LPW_VEC_T2_OVF;
                    `LPW_SRC_T2_CH1:   irq_vec = `LPW_VEC_T2_CH1;
                    `LPW_SRC_T2_CH0:   irq_vec = `LPW_VEC_T2_CH0;
                    `LPW_SRC_T2_CH5:   irq_vec = `LPW_VEC_T2_CH5;
                    `LPW_SRC_T2_CH4:   irq_vec = `LPW_VEC_T2_CH5 + `LPW_VEC_STEP;
                    `LPW_SRC_T2_CH3:   irq_vec = `LPW_VEC_T2_CH5 + 16'h0004;
                    `LPW_SRC_T2_CH2:   irq_vec = `LPW_VEC_T2_CH5 + 16'h0006;
                    `LPW_SRC_SPI_TX:   irq_vec = `LPW_VEC_SPI_TX;
                    `LPW_SRC_SPI_RX:   irq_vec = `LPW_VEC_SPI_RX;
                    `LPW_SRC_SER_TX:   irq_vec = `LPW_VEC_SER_TX;
                    `LPW_SRC_SER_RX:   irq_vec = `LPW_VEC_SER_RX;
                    `LPW_SRC_SER_ERR:  irq_vec = `LPW_VEC_SER_ERR;
                    `LPW_SRC_ADC:      irq_vec = `LPW_VEC_ADC;
                    `LPW_SRC_TICK:     irq_vec = `LPW_VEC_TICK;
                    `LPW_SRC_CAN_TX:   irq_vec = `LPW_VEC_CAN_TX;
                    `LPW_SRC_CAN_RX:   irq_vec = `LPW_VEC_CAN_TX + `LPW_VEC_STEP;
                    `LPW_SRC_CAN_ERR:  irq_vec = `LPW_VEC_CAN_TX + 16'h0004;
                    `LPW_SRC_CAN_WAKE: irq_vec = `LPW_VEC_CAN_TX + 16'h0006;
                    default:           irq_vec = `LPW_VEC_RESET;
                endcase
            end
        end
    end

    // ----------------------------------------
    // mode machine
    // ----------------------------------------
    always @* begin
        nxt_mode         = mode_ff;
        nxt_recover_cnt  = recover_cnt_ff;
        nxt_reset_exit   = reset_exit_ff;
        nxt_vector_valid = vector_valid & ~vector_ack;
        nxt_vector_addr  = vector_addr;
        case (mode_ff)
            ST_RUN: begin
                if (stop_instr & stop_enable) begin
                    nxt_mode = ST_STOP;
                end else if (wait_instr) begin
                    nxt_mode = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (any_reset) begin
                    nxt_mode         = ST_RUN;
                    nxt_vector_valid = 1'b1;
                    nxt_vector_addr  = `LPW_VEC_RESET;
                end else if (ext_wake) begin
                    nxt_mode         = ST_RUN;
                    nxt_vector_valid = 1'b1;
                    nxt_vector_addr  = `LPW_VEC_EXT_IRQ;
                end else if (key_wake) begin
                    nxt_mode         = ST_RUN;
                    nxt_vector_valid = 1'b1;
                    nxt_vector_addr  = `LPW_VEC_KEYPAD;
                end else if (irq_any) begin
                    nxt_mode         = ST_RUN;
                    nxt_vector_valid = 1'b1;
                    nxt_vector_addr  = irq_vec;
                end
            end
            ST_STOP: begin
                if (any_reset | ext_wake | key_wake | stop_irq) begin
                    nxt_mode        = ST_RECOVER;
                    nxt_reset_exit  = any_reset;
                    nxt_recover_cnt = short_recovery_select ? `LPW_RECOVER_SHORT : `LPW_RECOVER_LONG;
                    if (any_reset) begin
                        nxt_vector_addr = `LPW_VEC_RESET;
                    end else if (ext_wake) begin
                        nxt_vector_addr = `LPW_VEC_EXT_IRQ;
                    end else if (key_wake) begin
                        nxt_vector_addr = `LPW_VEC_KEYPAD;
                    end else begin
                        nxt_vector_addr = `LPW_VEC_TICK;
                    end
                end
            end
            ST_RECOVER: begin
                if (ref_clk_tick) begin
                    if (recover_cnt_ff == 12'h000) begin
                        nxt_mode         = ST_RUN;
                        nxt_vector_valid = 1'b1;
                        nxt_reset_exit   = 1'b0;
                    end else begin
                        nxt_recover_cnt = recover_cnt_ff - 12'h001;
                    end
                end
            end
            default: begin
                nxt_mode = ST_RUN;
            end
        endcase
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff        <= ST_RUN;
            recover_cnt_ff <= 12'h000;
            reset_exit_ff  <= 1'b0;
            stop_clear_ff  <= 1'b0;
            vector_valid   <= 1'b0;
            vector_addr    <= `LPW_VEC_RESET;
        end else begin
            mode_ff        <= nxt_mode;
            recover_cnt_ff <= nxt_recover_cnt;
            reset_exit_ff  <= nxt_reset_exit;
            stop_clear_ff  <= (nxt_mode == ST_STOP) & (mode_ff != ST_STOP);
            vector_valid   <= nxt_vector_valid;
            vector_addr    <= nxt_vector_addr;
        end
    end

    // ----------------------------------------
    // clock gating and access
    // ----------------------------------------
    wire halted = in_stop | in_rec;

    assign cpu_clk_en         = (mode_ff == ST_RUN);
    assign bus_clk_en         = ~halted;
    assign watchdog_clk_en    = ~halted;
    assign sys_count_clear    = stop_clear_ff;
    assign serial_clk_en      = ~halted;
    assign spi_clk_en         = ~halted;
    assign spi_abort          = in_rec & reset_exit_ff;
    assign timer_clk_en       = ~halted;
    assign tick_clk_en        = tick_live & ~in_rec;
    assign tick_reg_access_en = (mode_ff == ST_RUN);
    assign can_clk_en         = ~halted;
    assign can_reg_access_en  = (mode_ff == ST_RUN);
    assign supply_monitor_en  = supply_enable;
    assign chip_reset_req     = any_reset;
    assign power_mode         = mode_ff;

endmodule // lpw_wake_ctrl

`default_nettype wire

// >>> tb/lpw_wake_ctrl_monitor.sv
// port assertions for the low power wake controller
// assumes the design top lpw_wake_ctrl and its constants header
`timescale 1ns/10ps
`default_nettype none
`include "lpw_consts.vh"
module lpw_wake_ctrl_monitor (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        wait_instr,
    input wire logic        stop_instr,
    input wire logic        stop_enable,
    input wire logic [23:0] irq_req,
    input wire logic [23:0] irq_enable,
    input wire logic        vector_ack,
    input wire logic        chip_reset_req,
    input wire logic        cpu_clk_en,
    input wire logic        watchdog_clk_en,
    input wire logic        sys_count_clear,
    input wire logic        serial_clk_en,
    input wire logic        spi_clk_en,
    input wire logic        timer_clk_en,
    input wire logic        can_clk_en,
    input wire logic        tick_reg_access_en,
    input wire logic        vector_valid,
    input wire logic [15:0] vector_addr,
    input wire logic [1:0]  power_mode
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // run mode with nothing pending, so an instruction is taken
    wire logic idle_run = power_mode == `LPW_MODE_RUN && !vector_valid && !chip_reset_req;
    wire logic in_wait  = power_mode == `LPW_MODE_WAIT;
    wire logic in_stop  = power_mode == `LPW_MODE_STOP;

    a_wait_entry: assert property (idle_run && wait_instr && !stop_instr
        |=> in_wait && !cpu_clk_en) else $error("wait not entered");
    a_stop_refused: assert property (idle_run && stop_instr && !stop_enable
        |=> !in_stop) else $error("stop taken while disabled");
    a_stop_entry: assert property (idle_run && stop_instr && stop_enable
        |=> in_stop && !watchdog_clk_en) else $error("stop entry wrong");
    a_count_clear: assert property (in_stop && $past(power_mode) == `LPW_MODE_RUN
        |-> ##[0:1] sys_count_clear) else $error("counter clear missing");
    a_wait_clocks: assert property (in_wait |-> watchdog_clk_en && serial_clk_en
        && spi_clk_en && timer_clk_en && can_clk_en) else $error("unit halted in wait");
    a_stop_halt: assert property (in_stop |-> !cpu_clk_en && !serial_clk_en
        && !spi_clk_en && !timer_clk_en && !can_clk_en) else $error("unit running in stop");
    a_tick_blocked: assert property ((in_wait || in_stop) |-> !tick_reg_access_en)
        else $error("tick register reachable");
    a_wait_wake: assert property (in_wait && !chip_reset_req && (irq_req & irq_enable & 24'hfffffe) != 24'h0
        |=> power_mode == `LPW_MODE_RUN && vector_valid) else $error("wait wake missed");
    a_vector_hold: assert property (vector_valid && !vector_ack && !chip_reset_req
        |=> vector_valid && $stable(vector_addr)) else $error("vector not held");
    a_ack_clear: assert property (vector_valid && vector_ack |=> !vector_valid)
        else $error("vector not cleared");
endmodule // lpw_wake_ctrl_monitor
bind lpw_wake_ctrl lpw_wake_ctrl_monitor mon (.clk_sys, .reset_n, .wait_instr, .stop_instr, .stop_enable,
    .irq_req, .irq_enable, .vector_ack, .chip_reset_req, .cpu_clk_en, .watchdog_clk_en, .sys_count_clear,
    .serial_clk_en, .spi_clk_en, .timer_clk_en, .can_clk_en, .tick_reg_access_en, .vector_valid,
    .vector_addr, .power_mode);
`default_nettype wire

// >>> tb/lpw_core_model.sv
// processor core model: takes each presented vector with a one-cycle ack
// assumes vector_valid stands until acknowledged; slow adds a few cycles
`timescale 1ns/10ps
`default_nettype none
module lpw_core_model (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic vector_valid,
    input  wire logic slow,
    output var  logic vector_ack
);
    logic [2:0] wait_ff;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wait_ff    <= 3'h0;
            vector_ack <= 1'b0;
        end else if (vector_valid && !vector_ack) begin
            wait_ff    <= wait_ff + 3'h1;
            vector_ack <= !slow || wait_ff == 3'h4;
        end else begin
            wait_ff    <= 3'h0;
            vector_ack <= 1'b0;
        end
    end
endmodule // lpw_core_model
`default_nettype wire

// >>> tb/lpw_wake_ctrl_test.sv
// self-checking bench for the low power wake controller
// assumes the design, its constants header and the core model
`timescale 1ns/10ps
`default_nettype none
`include "lpw_consts.vh"
module lpw_wake_ctrl_test;
    logic        clk_sys = 1'b0, reset_n = 1'b0, slow = 1'b0;
    logic        wait_instr = 1'b0, stop_instr = 1'b0, stop_enable = 1'b0, short_recovery_select = 1'b0;
    logic        osc_keep_running = 1'b0, ref_clk_tick = 1'b0, reset_pin_n = 1'b1, ext_irq_pin = 1'b1;
    logic        watchdog_enable = 1'b0, watchdog_timeout = 1'b0, ext_request_mask = 1'b0;
    logic        supply_enable = 1'b0, supply_reset_enable = 1'b0, supply_trip_level = 1'b0;
    logic        keypad_request = 1'b0, keypad_request_mask = 1'b0;
    logic [23:0] irq_req = 24'h0, irq_enable = 24'hffffff;
    wire         vector_ack, cpu_clk_en, bus_clk_en, watchdog_clk_en, sys_count_clear, serial_clk_en;
    wire         spi_clk_en, spi_abort, timer_clk_en, tick_clk_en, tick_reg_access_en, can_clk_en;
    wire         can_reg_access_en, supply_monitor_en, chip_reset_req, vector_valid;
    wire [15:0]  vector_addr;
    wire [1:0]   power_mode;
    int          miscompares = 0;
    int          checks = 0;
    // expected vector for each request index, index 0 unused
    logic [15:0] rows [24] = '{16'h0, 16'hfff8, 16'hfff2, 16'hfff4, 16'hfff6, 16'hffe0, 16'hffe2, 16'hffe4,
        16'hffe6, 16'hffe8, 16'hffea, 16'hffec, 16'hffee, 16'hfff0, 16'hffde, 16'hffdc, 16'hffd4, 16'hffd6,
        16'hffd8, 16'hffda, 16'hffd2, 16'hffd0, 16'hffce, 16'hffcc};

    lpw_wake_ctrl dut (.*);
    lpw_core_model core (.clk_sys, .reset_n, .vector_valid, .slow, .vector_ack);

    always #50 clk_sys = ~clk_sys;

    task automatic conclude;
        if (miscompares == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic mode_is(input logic [1:0] m);
        check({14'h0, power_mode}, {14'h0, m});
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            ref_clk_tick = 1'b1;
            cyc(1);
            ref_clk_tick = 1'b0;
            cyc(1);
        end
    endtask

    task automatic take_vec(input logic [15:0] exp);
        int i;
        for (i = 0; i < 40 && vector_valid !== 1'b1; i++) cyc(1);
        check({15'h0, vector_valid}, 16'h1);
        check(vector_addr, exp);
        irq_req = 24'h0;
        keypad_request = 1'b0;
        ext_irq_pin = 1'b1;
        for (i = 0; i < 20 && vector_valid !== 1'b0; i++) cyc(1);
    endtask

    task automatic go_low(input logic stop);
        wait_instr = !stop;
        stop_instr = stop;
        cyc(1);
        {wait_instr, stop_instr} = 2'h0;
        mode_is(stop ? `LPW_MODE_STOP : `LPW_MODE_WAIT);
        check({15'h0, cpu_clk_en}, 16'h0);
        if (!stop) begin
            check({15'h0, bus_clk_en}, 16'h1);
            check({15'h0, can_reg_access_en}, 16'h0);
        end
    endtask

    initial begin
        cyc(10);
        mode_is(`LPW_MODE_RUN);
        check(vector_addr, `LPW_VEC_RESET);
        reset_n = 1'b1;
        cyc(2);
        for (int i = 1; i < 24; i++) begin
            slow = i[0];
            go_low(1'b0);
            irq_req[i] = 1'b1;
            take_vec(rows[i]);
        end
        go_low(1'b0);
        {irq_enable[3], irq_req[3], keypad_request_mask, keypad_request} = 4'h7;
        cyc(5);
        mode_is(`LPW_MODE_WAIT);
        {irq_enable[3], keypad_request_mask} = 2'h2;
        take_vec(`LPW_VEC_KEYPAD);
        go_low(1'b0);
        ext_irq_pin = 1'b0;
        take_vec(`LPW_VEC_EXT_IRQ);
        for (int k = 0; k < 3; k++) begin
            go_low(1'b0);
            reset_pin_n = k != 0;
            {watchdog_enable, watchdog_timeout} = {2{k == 1}};
            {supply_enable, supply_reset_enable, supply_trip_level} = {3{k == 2}};
            cyc(1);
            check({15'h0, chip_reset_req}, 16'h1);
            reset_pin_n = 1'b1;
            {watchdog_enable, watchdog_timeout, supply_trip_level} = 3'h0;
            take_vec(`LPW_VEC_RESET);
        end
        stop_instr = 1'b1;
        cyc(1);
        stop_instr = 1'b0;
        mode_is(`LPW_MODE_RUN);
        stop_enable = 1'b1;
        short_recovery_select = 1'b1;
        go_low(1'b1);
        check({15'h0, watchdog_clk_en}, 16'h0);
        {irq_req[2], watchdog_enable, watchdog_timeout} = 3'h7;
        cyc(4);
        mode_is(`LPW_MODE_STOP);
        {irq_req[2], watchdog_enable, watchdog_timeout, ext_irq_pin} = 4'h0;
        cyc(4);
        mode_is(`LPW_MODE_RECOVER);
        ticks(31);
        check({15'h0, vector_valid}, 16'h0);
        ticks(1);
        take_vec(`LPW_VEC_EXT_IRQ);
        short_recovery_select = 1'b0;
        go_low(1'b1);
        {supply_enable, supply_reset_enable, supply_trip_level} = 3'h7;
        cyc(2);
        supply_trip_level = 1'b0;
        mode_is(`LPW_MODE_RECOVER);
        check({15'h0, spi_abort}, 16'h1);
        check({15'h0, supply_monitor_en}, 16'h1);
        ticks(4095);
        check({15'h0, vector_valid}, 16'h0);
        ticks(1);
        take_vec(`LPW_VEC_RESET);
        {osc_keep_running, short_recovery_select} = 2'h3;
        go_low(1'b1);
        check({15'h0, tick_clk_en}, 16'h1);
        irq_req[15] = 1'b1;
        cyc(3);
        mode_is(`LPW_MODE_RECOVER);
        ticks(32);
        take_vec(`LPW_VEC_TICK);
        conclude;
    end

    initial begin
        #2000000;
        miscompares++;
        conclude;
    end
endmodule // lpw_wake_ctrl_test
`default_nettype wire
